// file: design/hts_regs.svh
// Register offsets, field positions, reset values and timing counts of the sensor control block
`ifndef HTS_REGS_SVH
`define HTS_REGS_SVH

`define HTS_SLAVE_ADDR 7'h40
`define HTS_OFS_STATE 8'h00
`define HTS_OFS_RES_HI 8'h01
`define HTS_OFS_RES_LO 8'h02
`define HTS_OFS_SETUP 8'h03
`define HTS_OFS_PART 8'h11
`define HTS_BIT_PEND 0
`define HTS_BIT_START 0
`define HTS_BIT_HEAT 1
`define HTS_BIT_THERM 4
`define HTS_BIT_FAST 5
`define HTS_SETUP_MASK 8'h33
`define HTS_SETUP_RST 8'h00
`define HTS_STATE_RST 8'h01
`define HTS_RESULT_RST 16'h0000
`define HTS_CLK_HZ 50000000
`define HTS_CONV_NORM_US 5800
`define HTS_CONV_FAST_US 2600
`define HTS_CONV_NORM_CYC (`HTS_CONV_NORM_US * (`HTS_CLK_HZ / 1000000))
`define HTS_CONV_FAST_CYC (`HTS_CONV_FAST_US * (`HTS_CLK_HZ / 1000000))
`define HTS_RH_BITS 12
`define HTS_TEMP_BITS 14

`endif

// file: design/hts_pkg.sv
// Types shared by the sensor control block
package hts_pkg;
  typedef enum logic [5:0] {
    HTS_I_IDLE = 6'b000001,
    HTS_I_ADDR = 6'b000010,
    HTS_I_ACK = 6'b000100,
    HTS_I_RX = 6'b001000,
    HTS_I_TX = 6'b010000,
    HTS_I_MACK = 6'b100000
  } hts_i2c_st_t;
  typedef enum logic [2:0] {
    HTS_C_SLEEP = 3'b001,
    HTS_C_RUN = 3'b010,
    HTS_C_AWAKE = 3'b100
  } hts_conv_st_t;
endpackage

// file: design/hts_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module hts_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin_in,
  output logic level_q,
  output logic rise,
  output logic fall
);
  logic s1_q; // First stage, read only by s2
  logic s2_q;
  logic s3_q;

  // Shift chain; filtered level moves only when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else if (ce) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  // Edges of the filtered level, one cycle wide
  assign rise = ce && (s2_q == s3_q) && s3_q && !level_q;
  assign fall = ce && (s2_q == s3_q) && !s3_q && level_q;
endmodule
`default_nettype wire

// file: design/hts_conv.sv
// Conversion timer standing in for the analog front end
`timescale 1ns/100ps
`default_nettype none
`include "hts_regs.svh"
module hts_conv #(
  parameter int NORM_CYC = `HTS_CONV_NORM_CYC,
  parameter int FAST_CYC = `HTS_CONV_FAST_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic fast,
  output logic done
);
  logic [31:0] cnt_q; // Cycles left in the running conversion
  logic busy_q;

  // Load on start, count down, pulse done on the last cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cnt_q <= fast ? 32'(FAST_CYC) : 32'(NORM_CYC);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 32'h1;
        if (cnt_q == 32'h1) begin
          busy_q <= 1'b0;
        end
      end
    end
  end

  assign done = ce && busy_q && !start && (cnt_q == 32'h1);
endmodule
`default_nettype wire

// file: design/hts_top.sv
// I2C slave, register set and conversion control of the humidity/temperature sensor
// Notes on behaviour
// (R1) Slave only, answers address 0x40
// (R2) Link works up to 400 kHz clock
// (R3) Setup D0 write starts conversion, humidity default
// (R4) Status D0 high while converting, low done
// (R5) Host polls status before reading result
// (R6) Result high at 0x01, low at 0x02
// (R7) Humidity gives 12-bit code
// (R8) Writing 0x11 starts temperature conversion
// (R9) Temperature gives 14-bit code
// (R10) Conversion 5.8 ms, fast mode 2.6 ms
// (R11) Setup D1 keeps heater on
// (R12) Chip select high: standby, link disabled
// (R13) Two zero setup writes enter standby
// (R14) Temperature conversion ends in standby
// (R15) Temperature after humidity keeps device awake
// (R16) Part code: type high nibble, revision low
// (R17) First byte: address then direction bit
// (R18) Acknowledge by holding SDA low ninth clock
// (R19) Write: pointer byte then data byte
// (R20) Read after pointer write and repeated start
// (R21) Acked high byte followed by low byte
// (R22) Host writes reserved bits as zero only
// (R23) Result held until next conversion finishes
`timescale 1ns/100ps
`default_nettype none
`include "hts_regs.svh"
module hts_top
  import hts_pkg::*;
#(
  parameter logic [3:0] PART_TYPE = 4'h5, // Arbitrary value
  parameter logic [3:0] PART_REV = 4'h2, // Arbitrary value
  parameter int NORM_CYC = `HTS_CONV_NORM_CYC,
  parameter int FAST_CYC = `HTS_CONV_FAST_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_n,
  input wire logic [13:0] sample_code,
  output logic heater_on,
  output logic standby,
  output logic converting
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;
  logic cs_lvl;

  hts_sync u_scl (.clk(clk), .rst(rst), .ce(ce), .pin_in(scl_in), .level_q(scl_lvl),
    .rise(scl_rise), .fall(scl_fall));
  hts_sync u_sda (.clk(clk), .rst(rst), .ce(ce), .pin_in(sda_in), .level_q(sda_lvl),
    .rise(sda_rise), .fall(sda_fall));
  hts_sync u_cs (.clk(clk), .rst(rst), .ce(ce), .pin_in(chip_select_n), .level_q(cs_lvl),
    .rise(), .fall());

  // Sampling at 50 MHz gives ample margin for a 400 kHz bus clock (see R2)
  logic link_en;
  assign link_en = !cs_lvl; // Pin high cuts the link off (see R12)

  // Bus conditions seen while the clock is high
  logic start_cond, stop_cond;
  assign start_cond = link_en && scl_lvl && sda_fall;
  assign stop_cond = link_en && scl_lvl && sda_rise;
  logic sda_now; // SDA as of the edge an SCL rise is seen; the filtered level lags a cycle behind
  assign sda_now = sda_rise || (sda_lvl && !sda_fall);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] setup_q; // Setup register, reserved bits kept zero
  logic [15:0] result_q; // Last completed result
  logic pend_q; // Set by reset or a conversion start, cleared when a conversion finishes
  logic [7:0] ptr_q; // Register pointer
  logic clr_seen_q; // One zero write already seen
  hts_conv_st_t cst_q;

  // Register read decode, used for first byte and auto-advance
  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    case (a)
      `HTS_OFS_STATE: rd_reg = {7'h00, pend_q}; // see R4
      `HTS_OFS_RES_HI: rd_reg = result_q[15:8]; // see R6
      `HTS_OFS_RES_LO: rd_reg = result_q[7:0]; // see R6
      `HTS_OFS_SETUP: rd_reg = setup_q;
      `HTS_OFS_PART: rd_reg = {PART_TYPE, PART_REV}; // see R16
      default: rd_reg = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // I2C slave state machine
  hts_i2c_st_t ist_q;
  logic [7:0] sh_q; // Shift register
  logic [3:0] bit_q; // Bits handled in this byte
  logic rd_q; // Transaction is a read
  logic [1:0] wcnt_q;
  logic ack_q; // Master acknowledged the byte just sent
  logic wr_strobe; // One-cycle write of setup data
  logic [7:0] wr_data;

  // Byte completion terms
  logic byte_done;
  assign byte_done = scl_fall && (bit_q == 4'd7);

  // Link protocol: start, address, ack, data in and out
  always_ff @(posedge clk) begin
    if (rst) begin
      ist_q <= HTS_I_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'd0;
      rd_q <= 1'b0;
      wcnt_q <= 2'd0;
      ack_q <= 1'b0;
      ptr_q <= 8'h00;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (ce) begin
      if (!link_en || stop_cond) begin
        // Chip select high or stop: release the bus (see R12)
        ist_q <= HTS_I_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        // Start or repeated start: fresh address byte (see R20)
        ist_q <= HTS_I_ADDR;
        bit_q <= 4'hF; // The SCL fall that closes the start carries no bit
        sda_oe <= 1'b0;
      end else begin
        case (ist_q)
          HTS_I_IDLE: begin
            sda_oe <= 1'b0;
          end
          HTS_I_ADDR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_now};
            end
            if (byte_done) begin
              bit_q <= 4'd0;
              // Seven address bits then direction (see R17)
              if (sh_q[7:1] == `HTS_SLAVE_ADDR) begin // see R1
                rd_q <= sh_q[0];
                wcnt_q <= 2'd0;
                sda_oe <= 1'b1;
                sda_out <= 1'b0; // see R18
                ist_q <= HTS_I_ACK;
              end else begin
                ist_q <= HTS_I_IDLE; // Not ours
              end
            end else if (scl_fall) begin
              bit_q <= bit_q + 4'd1;
            end
          end
          HTS_I_ACK: begin
            // Held low across the ninth clock high phase (see R18)
            if (scl_fall) begin
              if (rd_q) begin
                sh_q <= rd_reg(ptr_q);
                sda_out <= rd_reg(ptr_q) >> 7 != 8'h00;
                sda_oe <= 1'b1;
                ist_q <= HTS_I_TX;
              end else begin
                sda_oe <= 1'b0;
                ist_q <= HTS_I_RX;
              end
            end
          end
          HTS_I_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_now};
            end
            if (byte_done) begin
              bit_q <= 4'd0;
              // Pointer byte first, then one data byte (see R19)
              if (wcnt_q == 2'd0) begin
                ptr_q <= sh_q;
              end
              if (wcnt_q != 2'd3) begin
                wcnt_q <= wcnt_q + 2'd1;
              end
              sda_oe <= 1'b1;
              sda_out <= 1'b0; // see R18
              ist_q <= HTS_I_ACK;
            end else if (scl_fall) begin
              bit_q <= bit_q + 4'd1;
            end
          end
          HTS_I_TX: begin
            if (byte_done) begin
              bit_q <= 4'd0;
              sda_oe <= 1'b0; // Release for master ack
              ist_q <= HTS_I_MACK;
            end else if (scl_fall) begin
              bit_q <= bit_q + 4'd1;
              sda_out <= sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
          HTS_I_MACK: begin
            if (scl_rise) begin
              ack_q <= !sda_now;
            end
            if (scl_fall) begin
              if (ack_q) begin
                // Master acked: advance, high byte leads to low (see R21)
                sh_q <= rd_reg(ptr_q + 8'h01);
                sda_out <= rd_reg(ptr_q + 8'h01) >> 7 != 8'h00;
                ptr_q <= ptr_q + 8'h01;
                sda_oe <= 1'b1;
                ist_q <= HTS_I_TX;
              end else begin
                ist_q <= HTS_I_IDLE;
              end
            end
          end
          default: begin
            ist_q <= HTS_I_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Data byte write strobe: second byte of a write, on its acknowledge
  assign wr_strobe = ce && link_en && !start_cond && !stop_cond && (ist_q == HTS_I_RX) && byte_done
    && (wcnt_q == 2'd1) && (ptr_q == `HTS_OFS_SETUP);
  // Reserved bits forced to zero in case the host slips (see R22)
  assign wr_data = sh_q & `HTS_SETUP_MASK;

  ////////////////////////////////////////////////////////////////////////
  // Conversion control
  logic conv_start, conv_done;
  logic last_therm_q; // Kind of the running conversion
  logic after_rh_q; // A humidity conversion finished since the last double zero write
  assign conv_start = wr_strobe && wr_data[`HTS_BIT_START]; // see R3 R8

  hts_conv #(.NORM_CYC(NORM_CYC), .FAST_CYC(FAST_CYC)) u_conv (
    .clk(clk), .rst(rst), .ce(ce), .start(conv_start),
    .fast(wr_data[`HTS_BIT_FAST]), // see R10
    .done(conv_done)
  );

  // Setup register; heater follows its bit (see R11)
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_q <= `HTS_SETUP_RST;
    end else if (ce && wr_strobe) begin
      setup_q <= wr_data;
    end
  end
  assign heater_on = setup_q[`HTS_BIT_HEAT]; // see R11

  // Pending flag: start wins over completion (see R4 R23)
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b1;
    end else if (ce) begin
      if (conv_start) begin
        pend_q <= 1'b1; // see R23
      end else if (conv_done) begin
        pend_q <= 1'b0; // see R4
      end
    end
  end

  // Result capture; 12-bit humidity or 14-bit temperature (see R7 R9 R23)
  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= `HTS_RESULT_RST;
    end else if (ce && conv_done) begin
      if (last_therm_q) begin
        result_q <= {sample_code[`HTS_TEMP_BITS-1:0], 2'b00}; // see R9
      end else begin
        result_q <= {sample_code[`HTS_RH_BITS-1:0], 4'h0}; // see R7
      end
    end
  end

  // Power state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      cst_q <= HTS_C_SLEEP;
      last_therm_q <= 1'b0;
      after_rh_q <= 1'b0;
      clr_seen_q <= 1'b0;
    end else if (ce) begin
      if (wr_strobe) begin
        // Two zero writes in a row count as standby request (see R13)
        clr_seen_q <= (wr_data == 8'h00);
      end
      // Kind follows every start, a restart while running too (see R23)
      if (conv_start) begin
        last_therm_q <= wr_data[`HTS_BIT_THERM]; // see R3 R8
      end
      case (cst_q)
        HTS_C_SLEEP, HTS_C_AWAKE: begin
          if (conv_start) begin
            cst_q <= HTS_C_RUN;
          end else if (wr_strobe && wr_data == 8'h00 && clr_seen_q) begin
            cst_q <= HTS_C_SLEEP; // see R13
            after_rh_q <= 1'b0;
          end
        end
        HTS_C_RUN: begin
          if (conv_done) begin
            if (last_therm_q && !after_rh_q) begin
              cst_q <= HTS_C_SLEEP; // see R14
            end else begin
              cst_q <= HTS_C_AWAKE; // see R15
            end
            if (!last_therm_q) begin
              after_rh_q <= 1'b1;
            end
          end
        end
        default: begin
          cst_q <= HTS_C_SLEEP;
        end
      endcase
    end
  end

  // Standby whenever idle in sleep or chip select held high (see R12)
  assign standby = cs_lvl || (cst_q == HTS_C_SLEEP);
  assign converting = (cst_q == HTS_C_RUN);
endmodule
`default_nettype wire

// file: tb/hts_top_asserts.sv
// Port-level assertions of the sensor control block
`timescale 1ns/100ps
`default_nettype none
module hts_top_asserts #(
  parameter int NORM_CYC = 2000,
  parameter int FAST_CYC = 1000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_select_n,
  input wire logic heater_on,
  input wire logic standby,
  input wire logic converting
);
  int run_q; // Unbroken cycles of the running conversion
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Counter, since a repetition cannot span a whole conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= 0;
    end else begin
      run_q <= converting ? run_q + 1 : 0;
    end
  end
  ////////////////////////////////////////
  property p_idle; (scl_in && sda_in) [*8] |-> !sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("SDA pulled on an idle bus");
  property p_cs_sleep; chip_select_n [*8] |-> standby && !sda_oe; endproperty
  a_cs_sleep: assert property (p_cs_sleep) else $error("Deselected but awake");
  property p_cs_heat; chip_select_n [*8] |=> $stable(heater_on); endproperty
  a_cs_heat: assert property (p_cs_heat) else $error("Heater moved while deselected");
  property p_start; $rose(converting) |-> !standby ##[0:8] (sda_oe && !sda_out); endproperty
  a_start: assert property (p_start) else $error("Conversion began off a data ack");
  property p_max; converting |-> run_q <= NORM_CYC; endproperty
  a_max: assert property (p_max) else $error("Conversion ran too long");
  property p_min; $fell(converting) |-> run_q >= FAST_CYC - 2; endproperty
  a_min: assert property (p_min) else $error("Conversion ended too soon");
  // Late in a high phase the device side of SDA must hold still
  property p_steady; scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe) && $stable(sda_out); endproperty
  a_steady: assert property (p_steady) else $error("SDA moved while SCL high");
  property p_heat; $changed(heater_on) |-> ##[0:8] (sda_oe && !sda_out); endproperty
  a_heat: assert property (p_heat) else $error("Heater moved outside a write");
  property p_rst; $fell(rst) |-> standby && !converting && !heater_on && !sda_oe; endproperty
  a_rst: assert property (p_rst) else $error("Bad state after reset");
endmodule
bind hts_top hts_top_asserts #(.NORM_CYC(NORM_CYC), .FAST_CYC(FAST_CYC)) chk_u (.clk(clk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_n(chip_select_n),
  .heater_on(heater_on), .standby(standby), .converting(converting));
`default_nettype wire

// file: tb/hts_i2c_host.sv
// Behavioural I2C master facing the sensor's serial pins
`timescale 1ns/100ps
`default_nettype none
module hts_i2c_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // Idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Wait n clocks, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////
  // Long lead lets a held ack clear before SCL rises
  task automatic start();
    sda_m = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_m = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask
  // Nine clocks of 160 ns; a 1 releases SDA; read late in each high phase
  task automatic xfer(input logic [8:0] o, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_m = o[i];
      tick(2);
      scl = 1'b1;
      tick(4);
      r[i] = sda;
      scl = 1'b0;
      tick(2);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/humidity_temp_i2c_sensor_ctrl_bench.sv
// Self-checking bench of the sensor control block
`timescale 1ns/100ps
`default_nettype none
module humidity_temp_i2c_sensor_ctrl_bench;
  import hts_pkg::*;
  localparam int NORM = 2000; // Shortened conversion counts
  localparam int FAST = 1000;
  localparam logic [3:0] PT = 4'h3; // Arbitrary value
  localparam logic [3:0] PR = 4'h7; // Arbitrary value
  logic clk, rst, chip_select_n, sda_out, sda_oe, heater_on, standby, converting, scl, sda_m;
  logic [13:0] sample_code;
  logic [15:0] lfsr_q;
  logic [7:0] modes [6] = '{8'h11, 8'h03, 8'h31, 8'h00, 8'h11, 8'h21}; // 0x00 means double clear
  int fails, n_tests;
  wire sda_w;
  assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_m; // Pulled-up open-drain wire
  hts_top #(.PART_TYPE(PT), .PART_REV(PR), .NORM_CYC(NORM), .FAST_CYC(FAST)) dut_u (.clk(clk), .rst(rst),
    .ce(1'b1), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_n(chip_select_n),
    .sample_code(sample_code), .heater_on(heater_on), .standby(standby), .converting(converting));
  hts_i2c_host host_u (.clk(clk), .sda(sda_w), .scl(scl), .sda_m(sda_m));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Code is left-justified across the two bytes
  function automatic logic [15:0] exp_res(input logic [13:0] c, input logic t);
    return t ? {c, 2'h0} : {c[11:0], 4'h0};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One byte that the device must acknowledge
  task automatic send(input logic [7:0] b);
    logic [8:0] r;
    host_u.xfer({b, 1'b1}, r);
    chk({15'h0000, r[0]}, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host_u.start();
    send(8'h80);
    send(p);
    send(d);
    host_u.stop();
  endtask
  // Pointer write, repeated start, then one or two bytes high first
  task automatic rd(input logic [7:0] p, input logic two, output logic [15:0] v);
    logic [8:0] r;
    host_u.start();
    send(8'h80);
    send(p);
    host_u.start();
    send(8'h81);
    host_u.xfer({8'hFF, ~two}, r);
    v = {r[8:1], 8'h00};
    if (two) begin
      host_u.xfer(9'h1FF, r);
      v[7:0] = r[8:1];
    end
    host_u.stop();
  endtask
  ////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [8:0] r;
    logic hum_seen;
    int n;
    rst = 1'b1;
    chip_select_n = 1'b0;
    sample_code = 14'h0000;
    lfsr_q = 16'h8B52;
    fails = 0;
    n_tests = 0;
    hum_seen = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rd(8'h00, 1'b0, v);
    chk(v, 16'h0100);
    rd(8'h11, 1'b0, v);
    chk(v, {PT, PR, 8'h00});
    // Foreign address: top bit clear, so never ours
    host_u.start();
    host_u.xfer({1'b0, lfsr_q[5:0], lfsr_q[6], 1'b1}, r);
    host_u.stop();
    chk({15'h0000, r[0]}, 16'h0001);
    foreach (modes[k]) begin
      lfsr_q = lfsr_next(lfsr_q);
      sample_code = lfsr_q[13:0];
      wr(8'h03, modes[k]);
      if (modes[k] == 8'h00) begin
        wr(8'h03, 8'h00);
        chk({15'h0000, standby}, 16'h0001);
        hum_seen = 1'b0;
        continue;
      end
      rd(8'h00, 1'b0, v);
      chk(v, 16'h0100);
      chk({15'h0000, heater_on}, {15'h0000, modes[k][1]});
      n = 0;
      while (converting && n < 4000) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 4000) begin
        $display("ERROR at %0t: wait count %h, limit %h", $time, n, 4000);
        fails++;
        break;
      end
      chk({15'h0000, (n < FAST)}, {15'h0000, modes[k][5]});
      rd(8'h00, 1'b0, v);
      chk(v, 16'h0000);
      rd(8'h01, 1'b1, v);
      chk(v, exp_res(sample_code, modes[k][4]));
      hum_seen = hum_seen | ~modes[k][4];
      chk({15'h0000, standby}, {15'h0000, modes[k][4] & ~hum_seen});
      rd(8'h03, 1'b0, v);
      chk({11'h000, v[13:9]}, {11'h000, modes[k][5:1]});
    end
    // Deselected: asleep and deaf to its own address
    chip_select_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk({15'h0000, standby}, 16'h0001);
    host_u.start();
    host_u.xfer(9'h101, r);
    host_u.stop();
    chk({15'h0000, r[0]}, 16'h0001);
    chip_select_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rd(8'h11, 1'b0, v);
    chk(v, {PT, PR, 8'h00});
    // Pointer with its top bit set, right after the device's own ack
    rd(8'h84, 1'b0, v);
    chk(v, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
